// file: shared/dit_pkg.sv
package dit_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [3:0] T1_CNT_LO_IDX = 4'h4;
  localparam logic [3:0] T1_CNT_HI_IDX = 4'h5;
  localparam logic [3:0] T1_LAT_LO_IDX = 4'h6;
  localparam logic [3:0] T1_LAT_HI_IDX = 4'h7;
  localparam logic [3:0] T2_LO_IDX = 4'h8;
  localparam logic [3:0] T2_HI_IDX = 4'h9;
  localparam logic [3:0] AUX_CTRL_IDX = 4'hb;
  localparam logic [3:0] INT_FLAG_IDX = 4'hd;
  localparam logic [3:0] INT_EN_IDX = 4'he;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int ACR_WAVE_BIT = 7;
  localparam int ACR_FREE_BIT = 6;
  localparam int ACR_PULSE_BIT = 5;
  localparam int IFR_ANY_BIT = 7;
  localparam int IFR_T1_BIT = 6;
  localparam int IFR_T2_BIT = 5;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 5;

  // ****************************************************************
  // Reset values and widths
  // ****************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [31:0] RST_DATA = 32'h0000_0000;
  localparam logic [15:0] ONE_WORD = 16'h0001;
  localparam int ADDR_W = 6;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [3:0] idx;
    logic wr;
    logic [7:0] data;
  } dit_bus_type;

  typedef enum logic [0:0] {
    DIT_PHASE_IDLE = 1'b0,
    DIT_PHASE_DONE = 1'b1
  } dit_phase_type;

endpackage : dit_pkg

// file: rtl/dit_timers.sv
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps

module dit_timers (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dit_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pulse_count_pin,
  output logic timer_wave_pin,
  output logic timer_wave_pin_oe,
  output logic interrupt_request_low
);

  // ****************************************************************
  // State
  // ****************************************************************
  dit_pkg::dit_phase_type phase_q;
  dit_pkg::dit_phase_type phase_d;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [7:0] aux_control_reg_q;
  logic [7:0] ien_q;
  logic [15:0] t1_cnt_q;
  logic [15:0] t1_cnt_d;
  logic [7:0] t1_lat_lo_q;
  logic [7:0] t1_lat_lo_d;
  logic [7:0] t1_lat_hi_q;
  logic [7:0] t1_lat_hi_d;
  logic t1_arm_q;
  logic t1_arm_d;
  logic timer_one_flag_q;
  logic timer_one_flag_d;
  logic wave_q;
  logic wave_d;
  logic [15:0] t2_cnt_q;
  logic [15:0] t2_cnt_d;
  logic [7:0] t2_lat_q;
  logic [7:0] t2_lat_d;
  logic t2_arm_q;
  logic t2_arm_d;
  logic timer_two_flag_q;
  logic timer_two_flag_d;
  logic irq_n_q;
  logic pc_s1_q;
  logic pc_s2_q;
  logic pc_s3_q;
  logic pc_lvl_q;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  dit_pkg::dit_bus_type bus;
  wire access_wait = psel & penable & (phase_q == dit_pkg::DIT_PHASE_IDLE);
  wire done = psel & penable & (phase_q == dit_pkg::DIT_PHASE_DONE);
  wire wr_en = done & bus.wr;
  wire rd_en = done & ~bus.wr;
  wire mapped = (bus.idx >= dit_pkg::T1_CNT_LO_IDX &&
                 bus.idx <= dit_pkg::T2_HI_IDX) ||
                bus.idx == dit_pkg::AUX_CTRL_IDX ||
                bus.idx == dit_pkg::INT_FLAG_IDX ||
                bus.idx == dit_pkg::INT_EN_IDX;

  // Index, direction and low data byte in one word
  assign bus = {paddr[dit_pkg::IDX_MSB:dit_pkg::IDX_LSB], pwrite,
                pwdata[7:0]};
  assign phase_d = access_wait ? dit_pkg::DIT_PHASE_DONE
                              : dit_pkg::DIT_PHASE_IDLE;

  function automatic logic wr_at(input dit_pkg::dit_bus_type b,
                                 input logic en, input logic [3:0] idx);
    wr_at = en & (b.idx == idx);
  endfunction : wr_at

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  wire t1_free = aux_control_reg_q[dit_pkg::ACR_FREE_BIT];
  wire t1_wave_en = aux_control_reg_q[dit_pkg::ACR_WAVE_BIT];
  wire t2_pulse = aux_control_reg_q[dit_pkg::ACR_PULSE_BIT];
  wire irq_any = (timer_one_flag_q & ien_q[dit_pkg::IFR_T1_BIT]) |
                 (timer_two_flag_q & ien_q[dit_pkg::IFR_T2_BIT]);
  wire ifr_wr = wr_at(bus, wr_en, dit_pkg::INT_FLAG_IDX);
  // Only the two timer enable bits exist
  wire [7:0] ien_keep = (8'h01 << dit_pkg::IFR_T1_BIT) |
                        (8'h01 << dit_pkg::IFR_T2_BIT);

  // ****************************************************************
  // Timer one
  // ****************************************************************
  wire t1_load = wr_at(bus, wr_en, dit_pkg::T1_CNT_HI_IDX);
  wire t1_zero = (t1_cnt_q == dit_pkg::RST_WORD);
  wire t1_set = ~t1_load & t1_zero & (t1_free | t1_arm_q);
  wire t1_clr = wr_at(bus, rd_en, dit_pkg::T1_CNT_LO_IDX) |
                wr_at(bus, wr_en, dit_pkg::T1_LAT_HI_IDX) |
                (ifr_wr & bus.data[dit_pkg::IFR_T1_BIT]);

  // On load and free-run reload the low counter half comes from the low latch
  assign t1_lat_lo_d = (wr_at(bus, wr_en, dit_pkg::T1_CNT_LO_IDX) |
                        wr_at(bus, wr_en, dit_pkg::T1_LAT_LO_IDX))
                       ? bus.data : t1_lat_lo_q;
  assign t1_lat_hi_d = (t1_load | wr_at(bus, wr_en, dit_pkg::T1_LAT_HI_IDX))
                       ? bus.data : t1_lat_hi_q;
  assign t1_cnt_d = t1_load ? {bus.data, t1_lat_lo_q} :
                    (t1_zero & t1_free) ? {t1_lat_hi_q, t1_lat_lo_q} :
                    t1_cnt_q - dit_pkg::ONE_WORD;
  assign t1_arm_d = t1_load | (t1_arm_q & ~t1_set);
  // Set wins over t1_clr in the same cycle; a load clears the flag and blocks set
  assign timer_one_flag_d = t1_set |
                            (timer_one_flag_q & ~t1_clr & ~t1_load);
  assign wave_d = t1_load ? 1'b0 :
                  t1_set ? (t1_free ? ~wave_q : 1'b1) : wave_q;

  // ****************************************************************
  // Timer two
  // ****************************************************************
  wire pc_agree = (pc_s2_q == pc_s3_q);
  wire pc_fall = pc_lvl_q & pc_agree & ~pc_s3_q;
  wire t2_load = wr_at(bus, wr_en, dit_pkg::T2_HI_IDX);
  wire t2_dec = t2_pulse ? pc_fall : 1'b1;
  wire t2_zero = (t2_cnt_q == dit_pkg::RST_WORD);
  wire t2_set = ~t2_load & t2_dec & t2_zero & t2_arm_q;
  wire t2_clr = wr_at(bus, rd_en, dit_pkg::T2_LO_IDX) |
                (ifr_wr & bus.data[dit_pkg::IFR_T2_BIT]);

  assign t2_lat_d = wr_at(bus, wr_en, dit_pkg::T2_LO_IDX)
                    ? bus.data : t2_lat_q;
  assign t2_cnt_d = t2_load ? {bus.data, t2_lat_q} :
                    t2_dec ? t2_cnt_q - dit_pkg::ONE_WORD :
                    t2_cnt_q;
  assign t2_arm_d = t2_load | (t2_arm_q & ~t2_set);
  assign timer_two_flag_d = t2_set |
                            (timer_two_flag_q & ~t2_clr & ~t2_load);

  // ****************************************************************
  // Read data
  // ****************************************************************
  function automatic logic [7:0] rd_byte(input logic [3:0] idx);
    case (idx)
      dit_pkg::T1_CNT_LO_IDX: rd_byte = t1_cnt_q[7:0];
      dit_pkg::T1_CNT_HI_IDX: rd_byte = t1_cnt_q[15:8];
      dit_pkg::T1_LAT_LO_IDX: rd_byte = t1_lat_lo_q;
      dit_pkg::T1_LAT_HI_IDX: rd_byte = t1_lat_hi_q;
      dit_pkg::T2_LO_IDX: rd_byte = t2_cnt_q[7:0];
      dit_pkg::T2_HI_IDX: rd_byte = t2_cnt_q[15:8];
      dit_pkg::AUX_CTRL_IDX: rd_byte = aux_control_reg_q;
      dit_pkg::INT_FLAG_IDX: rd_byte = {irq_any, timer_one_flag_q,
                                        timer_two_flag_q, 5'h00};
      dit_pkg::INT_EN_IDX: rd_byte = ien_q;
      default: rd_byte = dit_pkg::RST_BYTE;
    endcase
  endfunction : rd_byte

  wire [31:0] rd_word = {24'h000000, rd_byte(bus.idx)};

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_q <= dit_pkg::DIT_PHASE_IDLE;
      prdata_q <= dit_pkg::RST_DATA;
      pslverr_q <= 1'b0;
    end
    else if (ce)
    begin
      phase_q <= phase_d;
      // Error flag stands only while pready does
      pslverr_q <= access_wait & ~mapped;
      if (access_wait)
      begin
        prdata_q <= pwrite ? dit_pkg::RST_DATA : rd_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      aux_control_reg_q <= dit_pkg::RST_BYTE;
      ien_q <= dit_pkg::RST_BYTE;
    end
    else if (ce)
    begin
      if (wr_at(bus, wr_en, dit_pkg::AUX_CTRL_IDX))
        aux_control_reg_q <= bus.data;
      if (wr_at(bus, wr_en, dit_pkg::INT_EN_IDX))
        ien_q <= bus.data & ien_keep;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      t1_cnt_q <= dit_pkg::RST_WORD;
      t1_lat_lo_q <= dit_pkg::RST_BYTE;
      t1_lat_hi_q <= dit_pkg::RST_BYTE;
      t1_arm_q <= 1'b0;
      timer_one_flag_q <= 1'b0;
      wave_q <= 1'b1;
    end
    else if (ce)
    begin
      t1_cnt_q <= t1_cnt_d;
      t1_lat_lo_q <= t1_lat_lo_d;
      t1_lat_hi_q <= t1_lat_hi_d;
      t1_arm_q <= t1_arm_d;
      timer_one_flag_q <= timer_one_flag_d;
      wave_q <= wave_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      t2_cnt_q <= dit_pkg::RST_WORD;
      t2_lat_q <= dit_pkg::RST_BYTE;
      t2_arm_q <= 1'b0;
      timer_two_flag_q <= 1'b0;
      irq_n_q <= 1'b1;
    end
    else if (ce)
    begin
      t2_cnt_q <= t2_cnt_d;
      t2_lat_q <= t2_lat_d;
      t2_arm_q <= t2_arm_d;
      timer_two_flag_q <= timer_two_flag_d;
      irq_n_q <= ~irq_any;
    end
  end

  // Pulse pin synchroniser; level follows once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_s1_q <= 1'b1;
      pc_s2_q <= 1'b1;
      pc_s3_q <= 1'b1;
      pc_lvl_q <= 1'b1;
    end
    else if (ce)
    begin
      pc_s1_q <= pulse_count_pin;
      pc_s2_q <= pc_s1_q;
      pc_s3_q <= pc_s2_q;
      if (pc_agree)
        pc_lvl_q <= pc_s3_q;
    end
  end

  assign prdata = prdata_q;
  assign pready = (phase_q == dit_pkg::DIT_PHASE_DONE);
  assign pslverr = pslverr_q;
  assign timer_wave_pin = wave_q;
  assign timer_wave_pin_oe = t1_wave_en;
  assign interrupt_request_low = irq_n_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_t1_load_value: assert property (ce && t1_load |=>
    t1_cnt_q == {$past(bus.data), $past(t1_lat_lo_q)})
    else $error("timer one load value wrong");
  a_t1_count_down: assert property (ce && !t1_load && !t1_zero |=>
    t1_cnt_q == $past(t1_cnt_q) - dit_pkg::ONE_WORD)
    else $error("timer one did not decrement");
  a_t1_single_flag: assert property (ce && !t1_free && !t1_arm_q &&
    !timer_one_flag_q |=> !timer_one_flag_q)
    else $error("timer one flag set twice");
  a_t1_wave_pulse: assert property (ce && t1_load |=> !timer_wave_pin)
    else $error("wave pin not low after load");
  a_t1_read_clear: assert property (ce &&
    wr_at(bus, rd_en, dit_pkg::T1_CNT_LO_IDX) && !t1_set |=>
    !timer_one_flag_q)
    else $error("timer one flag not cleared");
  a_t1_free_reload: assert property (ce && t1_free && t1_zero &&
    !t1_load |=> t1_cnt_q == {$past(t1_lat_hi_q), $past(t1_lat_lo_q)}
    && timer_one_flag_q && timer_wave_pin != $past(timer_wave_pin))
    else $error("free-run reload wrong");
  a_t2_wrap: assert property (ce && !t2_pulse && t2_zero &&
    !t2_load |=> t2_cnt_q == 16'hffff)
    else $error("timer two did not wrap");
  a_t2_single_flag: assert property (ce && !t2_arm_q &&
    !timer_two_flag_q |=> !timer_two_flag_q)
    else $error("timer two flag set without reload");
  a_irq_drive: assert property (ce && irq_any ##1 ce |->
    !interrupt_request_low)
    else $error("interrupt not asserted");
  a_t1_latch_only: assert property (ce &&
    (wr_at(bus, wr_en, dit_pkg::T1_CNT_LO_IDX) ||
     wr_at(bus, wr_en, dit_pkg::T1_LAT_LO_IDX) ||
     wr_at(bus, wr_en, dit_pkg::T1_LAT_HI_IDX)) && !t1_zero |=>
    t1_cnt_q == $past(t1_cnt_q) - dit_pkg::ONE_WORD)
    else $error("latch write disturbed timer one count");
  a_t1_latch_hi: assert property (ce &&
    wr_at(bus, wr_en, dit_pkg::T1_LAT_HI_IDX) && !t1_set |=>
    !timer_one_flag_q && t1_lat_hi_q == $past(bus.data))
    else $error("high latch write wrong");
  a_t1_flag_write: assert property (ce && ifr_wr &&
    bus.data[dit_pkg::IFR_T1_BIT] && !t1_set |=> !timer_one_flag_q)
    else $error("flag register write did not clear timer one");
  a_t1_shot_end: assert property (ce && !t1_free && t1_arm_q &&
    t1_zero && !t1_load |=> timer_wave_pin && timer_one_flag_q)
    else $error("one-shot end wrong");
  a_t1_shot_wrap: assert property (ce && !t1_free && t1_zero &&
    !t1_load |=> t1_cnt_q == ~dit_pkg::RST_WORD)
    else $error("one-shot did not wrap");
  a_t1_flag_bit: assert property (ce && access_wait && !pwrite &&
    bus.idx == dit_pkg::INT_FLAG_IDX |=>
    prdata[dit_pkg::IFR_T1_BIT] == $past(timer_one_flag_q))
    else $error("timer one flag bit misplaced");

  // ****************************************************************
  // Checks, timer two and interrupt
  // ****************************************************************
  a_t2_load_value: assert property (ce && t2_load |=>
    t2_cnt_q == {$past(bus.data), $past(t2_lat_q)} && !timer_two_flag_q)
    else $error("timer two load value wrong");
  a_t2_read_clear: assert property (ce &&
    wr_at(bus, rd_en, dit_pkg::T2_LO_IDX) && !t2_set |=>
    !timer_two_flag_q)
    else $error("timer two flag not cleared");
  a_t2_timed_step: assert property (ce && !t2_pulse && !t2_load |=>
    t2_cnt_q == $past(t2_cnt_q) - dit_pkg::ONE_WORD)
    else $error("timer two did not decrement");
  a_t2_pulse_hold: assert property (ce && t2_pulse && !pc_fall &&
    !t2_load |=> t2_cnt_q == $past(t2_cnt_q))
    else $error("timer two moved without a pulse");
  a_irq_quiet: assert property (ce && !irq_any ##1 ce |->
    interrupt_request_low)
    else $error("interrupt asserted without a flag");

  c_free_run: cover property (ce && t1_free && t1_zero ##1 t1_set);
  c_one_shot: cover property (t1_load ##[1:300] t1_set);
  c_pulse_zero: cover property (t2_pulse && t2_set);
  c_irq: cover property (!interrupt_request_low);
  c_t2_timed_zero: cover property (!t2_pulse && t2_set);

endmodule : dit_timers

// file: tb/dit_host.sv
`timescale 1ns/1ps

module dit_host (
  input wire logic pclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [dit_pkg::ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  output logic pulse_count_pin
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 6'h00;
    pwdata = 32'h0000_0000;
    pulse_count_pin = 1'b1;
  end

  // ****************************************************************
  // APB transfer, held until pready is sampled high
  // ****************************************************************
  task xfer(input logic wr, input logic [3:0] idx, input logic [7:0] wd,
            output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only pready sampled high or the bench watchdog ends this wait
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released address and data lines do not keep their last value
    paddr <= ~paddr;
    pwdata <= ~pwdata;
  endtask : xfer

  // Each pulse is held low across several rising edges
  task pulse;
    pulse_count_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    pulse_count_pin <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : pulse
endmodule : dit_host

// file: tb/tb.sv
`timescale 1ns/1ps

module tb;
  logic pclk;
  logic presetn;
  logic psel, penable, pwrite, pready, pslverr, pulse_pin;
  logic wave, wave_oe, irq_low;
  logic [dit_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  int mismatches = 0;
  int checks_done = 0;

  dit_timers dit_timers_i (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulse_count_pin(pulse_pin), .timer_wave_pin(wave),
    .timer_wave_pin_oe(wave_oe), .interrupt_request_low(irq_low));

  dit_host dit_host_i (.pclk(pclk), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pulse_count_pin(pulse_pin));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task wr(input logic [3:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    dit_host_i.xfer(1'b1, idx, d, r, e);
  endtask : wr

  task rd_chk(input logic [3:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    logic e;
    dit_host_i.xfer(1'b0, idx, 8'h00, r, e);
    check(r, {24'h000000, exp});
  endtask : rd_chk

  // Counts edges until the wave pin shows level v, or until 50 edges have passed
  task wave_wait(input logic v, output int n);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
      #1;
    end while (wave !== v && n < 50);
  endtask : wave_wait

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_regs;
    logic [31:0] r;
    logic e;
    dit_host_i.xfer(1'b0, 4'h0, 8'h00, r, e);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    wr(dit_pkg::AUX_CTRL_IDX, 8'ha5);
    rd_chk(dit_pkg::AUX_CTRL_IDX, 8'ha5);
    wr(dit_pkg::INT_EN_IDX, 8'h60);
    rd_chk(dit_pkg::INT_EN_IDX, 8'h60);
    wr(dit_pkg::INT_EN_IDX, 8'h00);
    $display("test regs done");
  endtask : t_regs

  task t_oneshot;
    int n;
    wr(dit_pkg::AUX_CTRL_IDX, 8'h80);
    wr(dit_pkg::INT_FLAG_IDX, 8'h60);
    wr(dit_pkg::T1_CNT_LO_IDX, 8'h05);
    wr(dit_pkg::T1_CNT_HI_IDX, 8'h00);
    #1;
    check({30'h0, wave, wave_oe}, 32'h1);
    wave_wait(1'b1, n);
    check(n, 32'd6);
    rd_chk(dit_pkg::T1_LAT_LO_IDX, 8'h05);
    rd_chk(dit_pkg::INT_FLAG_IDX, 8'h40);
    wr(dit_pkg::INT_FLAG_IDX, 8'h40);
    rd_chk(dit_pkg::INT_FLAG_IDX, 8'h00);
    wr(dit_pkg::T1_CNT_HI_IDX, 8'h00);
    repeat (10) @(posedge pclk);
    rd_chk(dit_pkg::T1_CNT_LO_IDX, 8'hf9);
    rd_chk(dit_pkg::INT_FLAG_IDX, 8'h00);
    repeat (20) @(posedge pclk);
    rd_chk(dit_pkg::INT_FLAG_IDX, 8'h00);
    $display("test oneshot done");
  endtask : t_oneshot

  task t_freerun;
    int n;
    wr(dit_pkg::INT_EN_IDX, 8'h40);
    wr(dit_pkg::AUX_CTRL_IDX, 8'hc0);
    wr(dit_pkg::T1_LAT_LO_IDX, 8'h03);
    wr(dit_pkg::T1_LAT_HI_IDX, 8'h00);
    wr(dit_pkg::T1_CNT_HI_IDX, 8'h00);
    wave_wait(1'b1, n);
    check(n, 32'd4);
    wave_wait(1'b0, n);
    check(n, 32'd4);
    check({31'h0, irq_low}, 32'h0);
    wr(dit_pkg::INT_EN_IDX, 8'h00);
    $display("test freerun done");
  endtask : t_freerun

  task t_timer2;
    wr(dit_pkg::AUX_CTRL_IDX, 8'h00);
    wr(dit_pkg::T1_LAT_HI_IDX, 8'h00);
    rd_chk(dit_pkg::INT_FLAG_IDX, 8'h00);
    rd_chk(dit_pkg::T1_CNT_HI_IDX, 8'hff);
    wr(dit_pkg::INT_FLAG_IDX, 8'h60);
    wr(dit_pkg::T2_LO_IDX, 8'h04);
    wr(dit_pkg::T2_HI_IDX, 8'h00);
    repeat (10) @(posedge pclk);
    rd_chk(dit_pkg::T2_HI_IDX, 8'hff);
    rd_chk(dit_pkg::INT_FLAG_IDX, 8'h20);
    rd_chk(dit_pkg::T2_LO_IDX, 8'hf0);
    rd_chk(dit_pkg::INT_FLAG_IDX, 8'h00);
    $display("test timer2 done");
  endtask : t_timer2

  task t_pulse;
    wr(dit_pkg::AUX_CTRL_IDX, 8'h20);
    wr(dit_pkg::T2_LO_IDX, 8'h02);
    wr(dit_pkg::T2_HI_IDX, 8'h00);
    dit_host_i.pulse();
    repeat (20) @(posedge pclk);
    rd_chk(dit_pkg::T2_LO_IDX, 8'h01);
    dit_host_i.pulse();
    dit_host_i.pulse();
    rd_chk(dit_pkg::T2_HI_IDX, 8'hff);
    rd_chk(dit_pkg::INT_FLAG_IDX, 8'h20);
    $display("test pulse done");
  endtask : t_pulse

  // ****************************************************************
  // Run control
  // ****************************************************************
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial
  begin
    #200000;
    mismatches++;
    print_verdict();
  end

  initial
  begin
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_oneshot();
    t_freerun();
    t_timer2();
    t_pulse();
    print_verdict();
  end
endmodule : tb
